// ---- design/ref_select_switchover.sv ----
// reference selection and hitless switchover control for one loop
// assumes monitor flags, phases and loop status arrive on clock_in;
// the manual select pin is asynchronous and is synchronised here
`timescale 1ns/10ps
`default_nettype none
module ref_select_switchover
    import ref_select_pkg::*;
(
    // clock and reset
    input  wire logic                       clock_in,
    input  wire logic                       rst_n_in,
    // register port
    input  wire logic [ADDR_W-1:0]          addr_in,
    input  wire logic [DATA_W-1:0]          wr_data_in,
    input  wire logic                       wr_en_in,
    input  wire logic                       rd_en_in,
    output logic [DATA_W-1:0]               rd_data_out,
    // reference monitors and measurements
    input  wire mon_flags_type              mon_flags0_in,
    input  wire mon_flags_type              mon_flags1_in,
    input  wire logic signed [PHASE_W-1:0]  phase0_in,
    input  wire logic signed [PHASE_W-1:0]  phase1_in,
    input  wire logic [FREQ_W-1:0]          freq0_in,
    input  wire logic [FREQ_W-1:0]          freq1_in,
    // loop status and pins
    input  wire logic                       history_valid_in,
    input  wire logic                       dpll_locked_in,
    input  wire logic                       man_sel_pin_in,
    // selection and phase outputs
    output logic                            ref_select_out,
    output logic                            ref_active_out,
    output logic                            holdover_out,
    output logic                            freerun_out,
    output logic signed [PHASE_W-1:0]       phase_adjust_out,
    output logic                            slew_active_out,
    output logic                            status_pin_out
);
    ctrl_type           ctrl_ff;
    logic [PRIO_W-1:0]  prio0_ff, prio1_ff;
    logic [MON_W-1:0]   mon0_ff, mon1_ff;
    logic [VTIME_W-1:0] vtime_ff;
    logic [SLEW_W-1:0]  step_ff, timer_ff;
    logic [DIV_W-1:0]   div0_ff, div1_ff;
    logic               nohitless_ff;
    logic               pin_meta_ff, pin_ff;
    loop_state_type     state_ff, nxt_state;
    logic               sel_ff, nxt_sel;
    logic signed [PHASE_W-1:0] offset_ff, nxt_offset;
    logic               soft_ff;
    logic [SLEW_W-1:0]  tick_cnt_ff;
    logic               valid0, valid1, elig0, elig1;
    logic               best_ok, best_idx, man_idx, man_ok, cur_ok;
    logic               tgt_ok, tgt_idx;
    logic               sw_evt, acq_evt, flock, hitless_ok;
    logic [FREQ_W+DIV_W-1:0] prod0, prod1;
    logic signed [PHASE_W-1:0] ph_old, ph_new, mag, step;
    logic               tick;
    logic               wr_status;

    // pin passes two flops before use
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            pin_meta_ff <= 1'b0;
            pin_ff      <= 1'b0;
        end else begin
            pin_meta_ff <= man_sel_pin_in;
            pin_ff      <= pin_meta_ff;
        end
    end

    // one validator per input
    ref_validator u_val0 (
        .clock_in      (clock_in),
        .rst_n_in      (rst_n_in),
        .flags_in      (mon_flags0_in),
        .enable_in     (mon0_ff),
        .valid_time_in (vtime_ff),
        .valid_out     (valid0)
    );

    ref_validator u_val1 (
        .clock_in      (clock_in),
        .rst_n_in      (rst_n_in),
        .flags_in      (mon_flags1_in),
        .enable_in     (mon1_ff),
        .valid_time_in (vtime_ff),
        .valid_out     (valid1)
    );

    // priority ranking, zero excluded, ties to input 0
    assign elig0    = valid0 && (prio0_ff != '0);
    assign elig1    = valid1 && (prio1_ff != '0);
    assign best_ok  = elig0 || elig1;
    assign best_idx = elig1 && (!elig0 || prio1_ff < prio0_ff);

    // manual choice: register field or synchronised pin
    assign man_idx = ctrl_ff.man_pin_source ? pin_ff
                                            : ctrl_ff.manual_ref_select;
    assign man_ok  = man_idx ? valid1 : valid0;
    assign cur_ok  = sel_ff ? elig1 : elig0;

    // target input for this cycle
    always_comb begin
        tgt_ok  = best_ok;
        tgt_idx = best_idx;
        unique case (ctrl_ff.mode)
            MODE_AUTO_REV: begin
                tgt_ok = best_ok;
            end
            MODE_AUTO_NONREV: begin
                if (state_ff == ST_TRACK && cur_ok) begin
                    tgt_idx = sel_ff;
                end
            end
            MODE_MAN_FALLBACK: begin
                if (man_ok) begin
                    tgt_ok  = 1'b1;
                    tgt_idx = man_idx;
                end
            end
            MODE_MAN_HOLDOVER: begin
                tgt_ok  = man_ok;
                tgt_idx = man_idx;
            end
        endcase
    end

    // loop state: track, else on leaving track holdover with history or free-run without; otherwise state held
    always_comb begin
        nxt_sel   = sel_ff;
        nxt_state = state_ff;
        if (tgt_ok) begin
            nxt_state = ST_TRACK;
            nxt_sel   = tgt_idx;
        end else if (state_ff == ST_TRACK) begin
            nxt_state = history_valid_in ? ST_HOLDOVER : ST_FREERUN;
        end
    end

    // registered select so the mux never glitches
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            state_ff <= ST_FREERUN;
            sel_ff   <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            sel_ff   <= nxt_sel;
        end
    end

    assign sw_evt  = state_ff == ST_TRACK && nxt_state == ST_TRACK && nxt_sel != sel_ff;
    assign acq_evt = state_ff != ST_TRACK && nxt_state == ST_TRACK;

    // locked when equal after each input's integer divider
    assign prod0 = freq0_in * div1_ff;
    assign prod1 = freq1_in * div0_ff;
    assign flock = prod0 == prod1 && freq0_in != '0;

    // pulse-per-second needs lock and no zero-delay sync
    assign hitless_ok = !ctrl_ff.pps_mode
                        || (!ctrl_ff.zero_delay_sync && dpll_locked_in);

    assign ph_old = sel_ff ? phase1_in : phase0_in;
    assign ph_new = nxt_sel ? phase1_in : phase0_in;

    // slew pacing: one step per timer period
    assign tick = tick_cnt_ff >= timer_ff;
    always_ff @(posedge clock_in) begin
        if (!rst_n_in || tick) begin
            tick_cnt_ff <= '0;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 16'h0001;
        end
    end

    // step limited release toward zero
    assign mag  = offset_ff[PHASE_W-1] ? -offset_ff : offset_ff;
    assign step = (mag > $signed(step_ff)) ? $signed(step_ff) : mag;

    // absorbed offset update
    always_comb begin
        nxt_offset = offset_ff;
        if (sw_evt) begin
            if (ctrl_ff.phase_cancel_enable && hitless_ok) begin
                nxt_offset = offset_ff + ph_old - ph_new;
            end else if (ctrl_ff.phase_slew_enable) begin
                nxt_offset = offset_ff + ph_old - ph_new;
            end else begin
                nxt_offset = '0;
            end
        end else if (acq_evt) begin
            // holdover or free-run exit: no phase jump under slew
            nxt_offset = ctrl_ff.phase_slew_enable ? -ph_new : '0;
        end else if (tick && (ctrl_ff.phase_slew_enable || soft_ff)) begin
            nxt_offset = offset_ff[PHASE_W-1] ? offset_ff + step
                                              : offset_ff - step;
        end
    end

    // unlocked switches with phase cancel on are released gradually even without slew
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            offset_ff <= '0;
            soft_ff   <= 1'b0;
        end else begin
            offset_ff <= nxt_offset;
            if (sw_evt && !flock && ctrl_ff.phase_cancel_enable) begin
                soft_ff <= 1'b1;
            end else if (offset_ff == '0) begin
                soft_ff <= 1'b0;
            end
        end
    end

    // sticky non-hitless flag, set wins over clear
    assign wr_status = wr_en_in && addr_in == OFS_STATUS && wr_data_in[ST_NOHITLESS];
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            nohitless_ff <= 1'b0;
        end else if (sw_evt && !hitless_ok) begin
            nohitless_ff <= 1'b1;
        end else if (wr_status) begin
            nohitless_ff <= 1'b0;
        end
    end

    // software writable configuration
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            ctrl_ff  <= CTRL_RST;
            prio0_ff <= PRIO0_RST;
            prio1_ff <= PRIO1_RST;
            mon0_ff  <= MON_RST;
            mon1_ff  <= MON_RST;
            vtime_ff <= VTIME_RST;
            step_ff  <= STEP_RST;
            timer_ff <= TIMER_RST;
            div0_ff  <= DIV_RST;
            div1_ff  <= DIV_RST;
        end else if (wr_en_in) begin
            unique case (addr_in)
                OFS_CTRL: ctrl_ff <= ctrl_type'(wr_data_in[CTRL_W-1:0]);
                OFS_PRIO: begin
                    prio0_ff <= wr_data_in[PRIO0_LSB +: PRIO_W];
                    prio1_ff <= wr_data_in[PRIO1_LSB +: PRIO_W];
                end
                OFS_MON: begin
                    mon0_ff <= wr_data_in[MON0_LSB +: MON_W];
                    mon1_ff <= wr_data_in[MON1_LSB +: MON_W];
                end
                OFS_VTIME: vtime_ff <= wr_data_in[VTIME_W-1:0];
                OFS_SLEW: begin
                    step_ff  <= wr_data_in[STEP_LSB +: SLEW_W];
                    timer_ff <= wr_data_in[TIMER_LSB +: SLEW_W];
                end
                OFS_DIV: begin
                    div0_ff <= wr_data_in[DIV0_LSB +: DIV_W];
                    div1_ff <= wr_data_in[DIV1_LSB +: DIV_W];
                end
                default: ;
            endcase
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clock_in) begin
        if (!rst_n_in || !rd_en_in) begin
            rd_data_out <= '0;
        end else begin
            unique case (addr_in)
                OFS_CTRL:   rd_data_out <= DATA_W'(ctrl_ff);
                OFS_PRIO:   rd_data_out <= {25'h0, prio1_ff, 1'b0, prio0_ff};
                OFS_MON:    rd_data_out <= {20'h0, mon1_ff, 4'h0, mon0_ff};
                OFS_VTIME:  rd_data_out <= {16'h0, vtime_ff};
                OFS_SLEW:   rd_data_out <= {timer_ff, step_ff};
                OFS_DIV:    rd_data_out <= {16'h0, div1_ff, div0_ff};
                OFS_STATUS: rd_data_out <= {23'h0, nohitless_ff, flock, soft_ff,
                                            valid1, valid0, state_ff == ST_FREERUN,
                                            state_ff == ST_HOLDOVER, state_ff == ST_TRACK,
                                            sel_ff};
                OFS_OFFSET: rd_data_out <= DATA_W'($unsigned(offset_ff));
                default:    rd_data_out <= '0;
            endcase
        end
    end

    // outputs straight from flops
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            ref_select_out   <= 1'b0;
            ref_active_out   <= 1'b0;
            holdover_out     <= 1'b0;
            freerun_out      <= 1'b1;
            phase_adjust_out <= '0;
            slew_active_out  <= 1'b0;
            status_pin_out   <= 1'b0;
        end else begin
            ref_select_out   <= nxt_sel;
            ref_active_out   <= nxt_state == ST_TRACK;
            holdover_out     <= nxt_state == ST_HOLDOVER;
            freerun_out      <= nxt_state == ST_FREERUN;
            phase_adjust_out <= nxt_offset;
            slew_active_out  <= nxt_offset != '0
                                && (ctrl_ff.phase_slew_enable || soft_ff);
            // pin shows selection or holdover as configured
            status_pin_out   <= ctrl_ff.status_pin_sel ? nxt_state == ST_HOLDOVER
                                                       : nxt_sel;
        end
    end

    // gapped inputs and detector pairing depend on host monitor setup

    sequence seq_plain_switch;
        sw_evt && !ctrl_ff.phase_cancel_enable && !ctrl_ff.phase_slew_enable;
    endsequence

    sequence seq_buildout_idle;
        state_ff == ST_TRACK && !sw_evt && !acq_evt && !soft_ff
        && ctrl_ff.phase_cancel_enable && !ctrl_ff.phase_slew_enable;
    endsequence

    AST_PRIO_ZERO: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        ctrl_ff.mode == MODE_AUTO_REV && (prio0_ff == '0 || prio1_ff == '0) && nxt_state == ST_TRACK
        |=> ref_select_out == ($past(prio0_ff) == '0))
        else $error("input with priority zero was selected");
    AST_TIE_LOW: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        ctrl_ff.mode == MODE_AUTO_REV && elig0 && elig1 && prio0_ff == prio1_ff
        |=> !sel_ff && state_ff == ST_TRACK)
        else $error("tie not resolved to input 0");
    AST_REVERT: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        ctrl_ff.mode == MODE_AUTO_REV && elig1 && (!elig0 || prio1_ff < prio0_ff)
        |=> sel_ff)
        else $error("revertive mode missed better input");
    AST_NONREV_KEEP: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        ctrl_ff.mode == MODE_AUTO_NONREV && state_ff == ST_TRACK && cur_ok
        |=> $stable(sel_ff))
        else $error("non-revertive mode left a valid input");
    AST_MAN_HOLD: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        ctrl_ff.mode == MODE_MAN_HOLDOVER && state_ff == ST_TRACK && !man_ok
        |=> state_ff == ($past(history_valid_in) ? ST_HOLDOVER : ST_FREERUN)
            && $past(history_valid_in) == holdover_out)
        else $error("manual holdover mode chose wrong state");
    AST_MAN_EXIT: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        ctrl_ff.mode[1] && state_ff == ST_HOLDOVER && man_ok
        |=> ref_active_out && ref_select_out == $past(man_idx))
        else $error("holdover not left on valid manual input");
    AST_STATUS_PIN: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        !ctrl_ff.status_pin_sel ##1 !$past(ctrl_ff.status_pin_sel)
        |-> status_pin_out == sel_ff)
        else $error("status pin does not show selection");
    AST_STEP_PASS: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        seq_plain_switch |=> phase_adjust_out == '0)
        else $error("phase step was absorbed without hitless");
    AST_BUILDOUT: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        seq_buildout_idle ##1 seq_buildout_idle |=> $stable(phase_adjust_out))
        else $error("absorbed offset drifted without slew");
endmodule // ref_select_switchover
`default_nettype wire

// ---- pkg/ref_select_pkg.sv ----
// package for the reference selection and switchover block
// assumes one 250 MHz control clock and a 32-bit word register port
package ref_select_pkg;
    localparam int DATA_W  = 32;
    localparam int ADDR_W  = 8;
    localparam int PRIO_W  = 3;
    localparam int PHASE_W = 16;
    localparam int FREQ_W  = 16;
    localparam int DIV_W   = 8;
    localparam int VTIME_W = 16;
    localparam int SLEW_W  = 16;
    localparam int MON_W   = 4;
    localparam int CTRL_W  = 9;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_PRIO   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_MON    = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_VTIME  = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_SLEW   = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_DIV    = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_OFFSET = 8'h1c;

    // field positions
    localparam int PRIO0_LSB  = 0;
    localparam int PRIO1_LSB  = 4;
    localparam int MON0_LSB   = 0;
    localparam int MON1_LSB   = 8;
    localparam int STEP_LSB   = 0;
    localparam int TIMER_LSB  = 16;
    localparam int DIV0_LSB   = 0;
    localparam int DIV1_LSB   = 8;
    localparam int ST_NOHITLESS = 8;

    // reset values
    localparam logic [PRIO_W-1:0]  PRIO0_RST = 3'h1;
    localparam logic [PRIO_W-1:0]  PRIO1_RST = 3'h2;
    localparam logic [MON_W-1:0]   MON_RST   = 4'h7;
    localparam logic [VTIME_W-1:0] VTIME_RST = 16'h0100;
    localparam logic [SLEW_W-1:0]  STEP_RST  = 16'h0001;
    localparam logic [SLEW_W-1:0]  TIMER_RST = 16'h0010;
    localparam logic [DIV_W-1:0]   DIV_RST   = 8'h01;

    typedef enum logic [1:0] {
        MODE_AUTO_REV, MODE_AUTO_NONREV, MODE_MAN_FALLBACK, MODE_MAN_HOLDOVER
    } sel_mode_type;

    typedef enum logic [1:0] {ST_FREERUN, ST_TRACK, ST_HOLDOVER} loop_state_type;

    // per-input monitor flags, high = monitor flags a fault
    typedef struct packed {
        logic phase_valid;
        logic runt;
        logic missing;
        logic freq;
    } mon_flags_type;

    typedef struct packed {
        logic         status_pin_sel;
        logic         pps_mode;
        logic         zero_delay_sync;
        logic         phase_slew_enable;
        logic         phase_cancel_enable;
        logic         man_pin_source;
        logic         manual_ref_select;
        sel_mode_type mode;
    } ctrl_type;

    localparam ctrl_type CTRL_RST = ctrl_type'(9'h010);
endpackage

// ---- design/ref_validator.sv ----
// validation timer for one reference input
// assumes monitor flags come from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
module ref_validator
    import ref_select_pkg::*;
(
    // clock and reset
    input  wire logic                clock_in,
    input  wire logic                rst_n_in,
    // monitor side
    input  wire mon_flags_type       flags_in,
    input  wire logic [MON_W-1:0]    enable_in,
    input  wire logic [VTIME_W-1:0]  valid_time_in,
    // result
    output logic                     valid_out
);
    logic [VTIME_W-1:0] clear_cnt_ff;
    logic               fault;

    // disabled monitors never disqualify
    assign fault = |(flags_in & enable_in);

    // count clean cycles, restart on any enabled flag
    always_ff @(posedge clock_in) begin
        if (!rst_n_in || fault) begin
            clear_cnt_ff <= '0;
            valid_out    <= 1'b0;
        end else if (clear_cnt_ff >= valid_time_in) begin
            valid_out <= 1'b1;
        end else begin
            clear_cnt_ff <= clear_cnt_ff + 16'h0001;
        end
    end

    AST_FLAG_DISQUALIFIES: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        fault |=> !valid_out)
        else $error("input stayed valid after an enabled flag");
endmodule // ref_validator
`default_nettype wire

// ---- verification/ref_source_model.sv ----
// two reference sources seen through their monitors
// assumes fault requests come from the bench on the control clock
`timescale 1ns/10ps
`default_nettype none
module ref_source_model
    import ref_select_pkg::*;
(
    // fault requests, bit per input
    input  wire logic [1:0]          fault_in,
    // monitor view
    output mon_flags_type            flags0_out,
    output mon_flags_type            flags1_out,
    output logic signed [PHASE_W-1:0] phase0_out,
    output logic signed [PHASE_W-1:0] phase1_out,
    output logic [FREQ_W-1:0]        freq0_out,
    output logic [FREQ_W-1:0]        freq1_out
);
    // faults show as missing pulses only, never as gap flags otherwise
    assign flags0_out = mon_flags_type'({2'h0, fault_in[0], 1'h0});
    assign flags1_out = mon_flags_type'({2'h0, fault_in[1], 1'h0});
    // equal rates, fixed phases: inputs frequency-locked while both dividers match
    assign phase0_out = 16'sh0064;
    assign phase1_out = 16'sh0028;
    assign freq0_out  = 16'h1000;
    assign freq1_out  = 16'h1000;
endmodule // ref_source_model
`default_nettype wire

// ---- verification/dpll_ref_select_switchover_bench.sv ----
// bench for reference selection: rows of mode cases, then hand cases
// assumes ref_source_model stands in for both reference inputs
`timescale 1ns/10ps
`default_nettype none
module dpll_ref_select_switchover_bench
    import ref_select_pkg::*;
;
    typedef struct packed {
        logic [8:0] ctrl;
        logic [7:0] prio;
        logic [1:0] flt;
        logic       pin;
        logic [3:0] exp;
    } row_type;
    // exp is {freerun, holdover, tracking, sel}; sel zero where not tracking
    localparam row_type ROWS [14] = '{
        '{9'h010, 8'h21, 2'h0, 1'h0, 4'h2}, '{9'h010, 8'h12, 2'h0, 1'h0, 4'h3},
        '{9'h010, 8'h11, 2'h0, 1'h0, 4'h2}, '{9'h010, 8'h01, 2'h1, 1'h0, 4'h4},
        '{9'h011, 8'h21, 2'h1, 1'h0, 4'h3}, '{9'h011, 8'h21, 2'h0, 1'h0, 4'h3},
        '{9'h012, 8'h21, 2'h0, 1'h0, 4'h2}, '{9'h012, 8'h21, 2'h1, 1'h0, 4'h3},
        '{9'h012, 8'h21, 2'h3, 1'h0, 4'h4}, '{9'h013, 8'h21, 2'h1, 1'h0, 4'h4},
        '{9'h013, 8'h21, 2'h0, 1'h0, 4'h2}, '{9'h017, 8'h21, 2'h0, 1'h0, 4'h3},
        '{9'h01b, 8'h21, 2'h0, 1'h1, 4'h3}, '{9'h01b, 8'h21, 2'h0, 1'h0, 4'h2}};
    localparam logic [7:0]  RA [6] = '{OFS_CTRL, OFS_PRIO, OFS_MON, OFS_VTIME, OFS_SLEW, OFS_DIV};
    localparam logic [31:0] RV [6] = '{32'h010, 32'h21, 32'h0707, 32'h0100, 32'h00100001, 32'h0101};
    logic                      clock_in = 1'b0;
    logic                      rst_n_in = 1'b0;
    logic [ADDR_W-1:0]         addr_in = 8'h00;
    logic [DATA_W-1:0]         wr_data_in = 32'h0, rd_data_out, rdv;
    logic                      wr_en_in = 1'b0, rd_en_in = 1'b0;
    logic                      history_valid_in = 1'b1, man_sel_pin_in = 1'b0, dpll_locked = 1'b1;
    logic [1:0]                fault = 2'h0;
    mon_flags_type             flags0, flags1;
    logic signed [PHASE_W-1:0] phase0, phase1, phase_adjust_out;
    logic [FREQ_W-1:0]         freq0, freq1;
    logic                      ref_select_out, ref_active_out, holdover_out, freerun_out;
    logic                      slew_active_out, status_pin_out;
    int                        num_errors = 0, total_checks = 0;

    // 250 MHz control clock
    always #2 clock_in = ~clock_in;

    ref_source_model u_src (.fault_in(fault), .flags0_out(flags0), .flags1_out(flags1),
        .phase0_out(phase0), .phase1_out(phase1), .freq0_out(freq0), .freq1_out(freq1));
    // locked held high except for the one pulse-per-second switch made before lock
    ref_select_switchover u_dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
        .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
        .mon_flags0_in(flags0), .mon_flags1_in(flags1), .phase0_in(phase0), .phase1_in(phase1),
        .freq0_in(freq0), .freq1_in(freq1), .history_valid_in(history_valid_in),
        .dpll_locked_in(dpll_locked), .man_sel_pin_in(man_sel_pin_in),
        .ref_select_out(ref_select_out), .ref_active_out(ref_active_out), .holdover_out(holdover_out),
        .freerun_out(freerun_out), .phase_adjust_out(phase_adjust_out),
        .slew_active_out(slew_active_out), .status_pin_out(status_pin_out));

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // strobe dropped a full cycle so no edge sees it assigned twice
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr_in <= a;
        wr_data_in <= d;
        wr_en_in <= 1'b1;
        @(posedge clock_in);
        wr_en_in <= 1'b0;
        @(posedge clock_in);
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        addr_in <= a;
        rd_en_in <= 1'b1;
        @(posedge clock_in);
        rd_en_in <= 1'b0;
        #1 d = rd_data_out;
        @(posedge clock_in);
    endtask
    task automatic outs(input logic [3:0] e);
        chk({freerun_out, holdover_out, ref_active_out, ref_select_out & e[1]}, e);
    endtask
    task automatic do_reset;
        rst_n_in <= 1'b0;
        repeat (10) @(posedge clock_in);
        rst_n_in <= 1'b1;
        @(posedge clock_in);
    endtask
    task automatic final_report;
        if (num_errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // hang guard
    initial begin
        repeat (100000) @(posedge clock_in);
        num_errors++;
        final_report;
    end

    // main sequence
    initial begin
        do_reset;
        outs(4'h8);
        for (int i = 0; i < 6; i++) begin
            rd_reg(RA[i], rdv);
            chk(rdv, RV[i]);
        end
        wr(OFS_VTIME, 32'h4);
        for (int i = 0; i < 14; i++) begin
            wr(OFS_CTRL, {23'h0, ROWS[i].ctrl});
            wr(OFS_PRIO, {24'h0, ROWS[i].prio});
            fault <= ROWS[i].flt;
            man_sel_pin_in <= ROWS[i].pin;
            repeat (20) @(posedge clock_in);
            outs(ROWS[i].exp);
            rd_reg(OFS_STATUS, rdv);
            chk(rdv[3:0] & {3'h7, ROWS[i].exp[1]}, ROWS[i].exp);
            chk(status_pin_out & ROWS[i].exp[1], ROWS[i].exp[0]);
        end
        // no history: manual input lost means free-run
        history_valid_in <= 1'b0;
        fault <= 2'h1;
        repeat (20) @(posedge clock_in);
        outs(4'h8);
        fault <= 2'h0;
        repeat (3) @(posedge clock_in);
        rd_reg(OFS_STATUS, rdv);
        chk(rdv[4], 1'b0);
        repeat (10) @(posedge clock_in);
        rd_reg(OFS_STATUS, rdv);
        chk(rdv[4], 1'b1);
        history_valid_in <= 1'b1;
        rd_reg(8'h40, rdv);
        chk(rdv, 32'h0);
        // mid-run reset, then phase handling across switches
        do_reset;
        wr(OFS_CTRL, 32'h0);
        wr(OFS_VTIME, 32'h4);
        wr(OFS_PRIO, 32'h12);
        repeat (20) @(posedge clock_in);
        outs(4'h3);
        chk({16'h0, phase_adjust_out}, 32'h0);
        wr(OFS_CTRL, 32'h010);
        wr(OFS_PRIO, 32'h21);
        repeat (20) @(posedge clock_in);
        chk({16'h0, phase_adjust_out}, 32'hffc4);
        repeat (100) @(posedge clock_in);
        chk({16'h0, phase_adjust_out}, 32'hffc4);
        // plain switch drops the absorbed offset, the step goes to the loop
        wr(OFS_CTRL, 32'h0);
        wr(OFS_PRIO, 32'h12);
        repeat (4) @(posedge clock_in);
        outs(4'h3);
        chk({16'h0, phase_adjust_out}, 32'h0);
        // holdover exit with slew on releases offset gradually, pin shows holdover
        wr(OFS_CTRL, 32'h130);
        fault <= 2'h3;
        repeat (20) @(posedge clock_in);
        outs(4'h4);
        chk(status_pin_out, 1'b1);
        fault <= 2'h0;
        repeat (20) @(posedge clock_in);
        chk(status_pin_out, 1'b0);
        chk(slew_active_out, 1'b1);
        chk(phase_adjust_out[15], 1'b1);
        // unequal dividers: no frequency lock, offset eased out without slew
        wr(OFS_CTRL, 32'h010);
        wr(OFS_DIV, 32'h0201);
        wr(OFS_PRIO, 32'h21);
        repeat (4) @(posedge clock_in);
        rd_reg(OFS_STATUS, rdv);
        chk(rdv[7:6], 2'h1);
        chk(slew_active_out, 1'b1);
        // pulse-per-second switch before lock is flagged and not hitless
        wr(OFS_DIV, 32'h0101);
        wr(OFS_CTRL, 32'h090);
        dpll_locked <= 1'b0;
        wr(OFS_PRIO, 32'h12);
        repeat (4) @(posedge clock_in);
        chk({16'h0, phase_adjust_out}, 32'h0);
        rd_reg(OFS_STATUS, rdv);
        chk(rdv[8], 1'b1);
        wr(OFS_STATUS, 32'h100);
        rd_reg(OFS_STATUS, rdv);
        chk(rdv[8], 1'b0);
        dpll_locked <= 1'b1;
        final_report;
    end
endmodule // dpll_ref_select_switchover_bench
`default_nettype wire
